// ===== design/irp_pkg.sv
// Package: register map, field positions and shared types of the IR pulse unit
package irp_pkg;

    localparam logic [11:0] OFF_CTRL     = 12'h000; // data_counter_control
    localparam logic [11:0] OFF_CNT      = 12'h004; // data_counter
    localparam logic [11:0] OFF_ACT_LEN  = 12'h008; // active_length
    localparam logic [11:0] OFF_BIT_LEN  = 12'h00C; // bit_length
    localparam logic [11:0] OFF_STATUS   = 12'h010; // flag_status
    localparam logic [11:0] OFF_IRQ_EN   = 12'h014; // interrupt enables
    localparam logic [11:0] OFF_CARRIER  = 12'h018; // carrier_setting

    // Control register bit positions
    localparam int CTL_MODULE_EN  = 0;
    localparam int CTL_SOFT_RST   = 1;
    localparam int CTL_ONESHOT    = 2;
    localparam int CTL_BUF_EN     = 3;
    localparam int CTL_INVERT     = 4;
    localparam int CTL_RUN        = 8;
    localparam int CTL_CNT_RST    = 9;

    // Status register bit positions
    localparam int ST_ACT_FLAG    = 0;
    localparam int ST_LEN_FLAG    = 1;
    localparam int ST_ACT_BUSY    = 8;
    localparam int ST_BIT_BUSY    = 9;
    localparam int ST_CNT_RUN     = 10;

    // Carrier register field positions
    localparam int CAR_DUTY_LSB   = 0;
    localparam int CAR_PER_LSB    = 8;

    localparam logic [15:0] DATA_ZERO = 16'h0000;
    localparam logic [7:0]  CARR_ZERO = 8'h00;

    typedef struct packed {
        logic        module_enable;
        logic        oneshot_select;
        logic        compare_buffer_enable;
        logic        output_invert;
    } irp_ctrl_t;

    typedef struct packed {
        logic        active_match_flag;
        logic        length_match_flag;
    } irp_flags_t;

endpackage

// ===== design/irp_pulse_unit.sv
// IR remote pulse unit: carrier, PWM data signal, compare buffers, APB regs
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
// What this block does
// - Remote output is carrier AND data
// - 8-bit carrier counter toggles at duty match
// - Period match toggles carrier, clears counter
// - Counter reset and run control both counters
// - 16-bit data counter toggles at active match
// - Length match toggles data, clears counter
// - Repeat mode cycles until run cleared
// - One-shot mode stops at first length match
// - Unbuffered compares use written lengths directly
// - Buffered compares use shadow buffers
// - Shadows load at end of each bit
// - Busy set on write, cleared on transfer
// - Active match flag, cleared by write-one or reset
// - Length match flag, cleared by write-one or reset
// - Interrupt only while flag and enable set
// - Pins driven only while running
// - Clear pulse high for length minus active
// - One-shot stop clears run control
// - Invert bit inverts remote output
// - Soft reset clears counters and flags, self-clears
// - Writes ignored while length busy
module irp_pulse_unit
    import irp_pkg::*;
(
    input  wire logic        core_clk,          // 100 MHz clock
    input  wire logic        resetn,            // Async reset, active low
    input  wire logic        psel,              // APB select
    input  wire logic        penable,           // APB access phase
    input  wire logic        pwrite,            // APB write
    input  wire logic [11:0] paddr,             // APB byte address
    input  wire logic [31:0] pwdata,            // APB write data
    output logic      [31:0] prdata,            // APB read data
    output logic             pready,            // APB ready
    output logic             pslverr,           // APB error
    output logic             remote_output_pin, // Modulated IR output
    output logic             clear_pulse_pin,   // EL lamp clear pulse
    output logic             irq                // Interrupt request
);

    // ========================================
    // Reset synchroniser
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ========================================
    // Bus decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    wire logic acc     = psel && penable;
    wire logic wr      = acc && pwrite;
    wire logic wr_ctl  = wr && hit(paddr, OFF_CTRL);
    wire logic wr_act  = wr && hit(paddr, OFF_ACT_LEN);
    wire logic wr_bit  = wr && hit(paddr, OFF_BIT_LEN);
    wire logic wr_st   = wr && hit(paddr, OFF_STATUS);
    wire logic wr_ie   = wr && hit(paddr, OFF_IRQ_EN);
    wire logic wr_car  = wr && hit(paddr, OFF_CARRIER);
    wire logic mapped  = hit(paddr, OFF_CTRL) || hit(paddr, OFF_CNT)
                      || hit(paddr, OFF_ACT_LEN) || hit(paddr, OFF_BIT_LEN)
                      || hit(paddr, OFF_STATUS) || hit(paddr, OFF_IRQ_EN)
                      || hit(paddr, OFF_CARRIER);
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    // ========================================
    // Registers
    irp_ctrl_t   ctl_reg;
    irp_flags_t  flag_reg;
    irp_flags_t  ie_reg;
    logic        run_reg;
    logic        soft_rst_reg;
    logic        cnt_rst_reg;
    logic [15:0] act_len_reg;
    logic [15:0] bit_len_reg;
    logic [15:0] act_buf_reg;
    logic [15:0] bit_buf_reg;
    logic        act_busy_reg;
    logic        bit_busy_reg;
    logic [7:0]  per_reg;
    logic [7:0]  duty_reg;
    logic [7:0]  car_cnt_reg;
    logic        car_wave_reg;
    logic [15:0] data_cnt_reg;
    logic        data_wave_reg;

    wire logic buf_en    = ctl_reg.compare_buffer_enable;
    wire logic [15:0] act_cmp = buf_en ? act_buf_reg : act_len_reg;
    wire logic [15:0] bit_cmp = buf_en ? bit_buf_reg : bit_len_reg;
    wire logic counting  = run_reg && !cnt_rst_reg && !soft_rst_reg;
    wire logic act_match = counting && (data_cnt_reg == act_cmp);
    wire logic bit_match = counting && (data_cnt_reg == bit_cmp);
    wire logic car_duty  = counting && (car_cnt_reg == duty_reg);
    wire logic car_per   = counting && (car_cnt_reg == per_reg);
    wire logic os_stop   = bit_match && ctl_reg.oneshot_select;
    // Writes to lengths honoured only when enabled and not pending transfer
    wire logic act_take  = wr_act && ctl_reg.module_enable
                        && !(buf_en && act_busy_reg);
    wire logic bit_take  = wr_bit && ctl_reg.module_enable
                        && !(buf_en && bit_busy_reg);
    wire logic ctl_rst   = wr_ctl && pwdata[CTL_SOFT_RST];

    // Control register and one-cycle counter/soft reset strobes
    always_ff @(posedge core_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            ctl_reg      <= '0;
            run_reg      <= 1'b0;
            soft_rst_reg <= 1'b0;
            cnt_rst_reg  <= 1'b0;
            ie_reg       <= '0;
            per_reg      <= CARR_ZERO;
            duty_reg     <= CARR_ZERO;
        end
        else
        begin
            soft_rst_reg <= ctl_rst;
            cnt_rst_reg  <= wr_ctl && pwdata[CTL_CNT_RST]
                         && pwdata[CTL_MODULE_EN] && !ctl_rst;
            if (wr_ctl)
            begin
                ctl_reg.module_enable         <= pwdata[CTL_MODULE_EN];
                ctl_reg.oneshot_select        <= pwdata[CTL_ONESHOT];
                ctl_reg.compare_buffer_enable <= pwdata[CTL_BUF_EN];
                ctl_reg.output_invert         <= pwdata[CTL_INVERT];
            end
            if (ctl_rst)
                run_reg <= 1'b0;
            else if (os_stop)
                run_reg <= 1'b0;
            else if (wr_ctl)
                run_reg <= pwdata[CTL_RUN] && pwdata[CTL_MODULE_EN];
            if (wr_ie)
                ie_reg <= {pwdata[ST_ACT_FLAG], pwdata[ST_LEN_FLAG]};
            if (wr_car)
            begin
                per_reg  <= pwdata[CAR_PER_LSB +: 8];
                duty_reg <= pwdata[CAR_DUTY_LSB +: 8];
            end
        end
    end

    // Length registers, shadows and busy flags
    always_ff @(posedge core_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            act_len_reg  <= DATA_ZERO;
            bit_len_reg  <= DATA_ZERO;
            act_buf_reg  <= DATA_ZERO;
            bit_buf_reg  <= DATA_ZERO;
            act_busy_reg <= 1'b0;
            bit_busy_reg <= 1'b0;
        end
        else
        begin
            if (act_take)
                act_len_reg <= pwdata[15:0];
            if (bit_take)
                bit_len_reg <= pwdata[15:0];
            // Shadows follow registers while unbuffered so enabling is clean
            if (!buf_en || bit_match)
            begin
                act_buf_reg <= act_len_reg;
                bit_buf_reg <= bit_len_reg;
            end
            if (buf_en && act_take)
                act_busy_reg <= 1'b1;
            else if (!buf_en || bit_match)
                act_busy_reg <= 1'b0;
            if (buf_en && bit_take)
                bit_busy_reg <= 1'b1;
            else if (!buf_en || bit_match)
                bit_busy_reg <= 1'b0;
        end
    end

    // ========================================
    // Counters and waveforms
    always_ff @(posedge core_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            car_cnt_reg   <= CARR_ZERO;
            car_wave_reg  <= 1'b1;
            data_cnt_reg  <= DATA_ZERO;
            data_wave_reg <= 1'b1;
        end
        else if (cnt_rst_reg || soft_rst_reg)
        begin
            car_cnt_reg   <= CARR_ZERO;
            car_wave_reg  <= 1'b1;
            data_cnt_reg  <= DATA_ZERO;
            data_wave_reg <= 1'b1;
        end
        else if (counting)
        begin
            if (car_per)
            begin
                car_cnt_reg  <= CARR_ZERO;
                car_wave_reg <= ~car_wave_reg;
            end
            else
            begin
                car_cnt_reg  <= car_cnt_reg + 8'h01;
                if (car_duty)
                    car_wave_reg <= ~car_wave_reg;
            end
            if (bit_match)
            begin
                data_cnt_reg  <= DATA_ZERO;
                data_wave_reg <= ~data_wave_reg;
            end
            else
            begin
                data_cnt_reg <= data_cnt_reg + 16'h0001;
                if (act_match)
                    data_wave_reg <= ~data_wave_reg;
            end
        end
    end

    // ========================================
    // Flags: hardware set wins over write-one clear
    always_ff @(posedge core_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            flag_reg <= '0;
        else
        begin
            if (act_match)
                flag_reg.active_match_flag <= 1'b1;
            else if (soft_rst_reg || (wr_st && pwdata[ST_ACT_FLAG]))
                flag_reg.active_match_flag <= 1'b0;
            if (bit_match)
                flag_reg.length_match_flag <= 1'b1;
            else if (soft_rst_reg || (wr_st && pwdata[ST_LEN_FLAG]))
                flag_reg.length_match_flag <= 1'b0;
        end
    end

    assign irq = |(flag_reg & ie_reg);

    // ========================================
    // Pins
    wire logic remote_output_pin_raw = car_wave_reg && data_wave_reg;
    always_ff @(posedge core_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            remote_output_pin <= 1'b0;
            clear_pulse_pin   <= 1'b0;
        end
        else
        begin
            // Gate on counting: the counter-reset cycle must not widen a pulse
            remote_output_pin <= counting
                              && (remote_output_pin_raw ^ ctl_reg.output_invert);
            clear_pulse_pin   <= counting && !data_wave_reg;
        end
    end

    // ========================================
    // Read mux
    always_comb
    begin
        prdata = '0;
        if (acc && !pwrite)
        begin
            case (paddr)
                OFF_CTRL:
                begin
                    prdata[CTL_MODULE_EN] = ctl_reg.module_enable;
                    prdata[CTL_SOFT_RST]  = soft_rst_reg;
                    prdata[CTL_ONESHOT]   = ctl_reg.oneshot_select;
                    prdata[CTL_BUF_EN]    = ctl_reg.compare_buffer_enable;
                    prdata[CTL_INVERT]    = ctl_reg.output_invert;
                    prdata[CTL_RUN]       = run_reg;
                    prdata[CTL_CNT_RST]   = cnt_rst_reg;
                end
                OFF_CNT:     prdata[15:0] = data_cnt_reg;
                OFF_ACT_LEN: prdata[15:0] = act_len_reg;
                OFF_BIT_LEN: prdata[15:0] = bit_len_reg;
                OFF_STATUS:
                begin
                    prdata[ST_ACT_FLAG] = flag_reg.active_match_flag;
                    prdata[ST_LEN_FLAG] = flag_reg.length_match_flag;
                    prdata[ST_ACT_BUSY] = act_busy_reg;
                    prdata[ST_BIT_BUSY] = bit_busy_reg;
                    prdata[ST_CNT_RUN]  = run_reg;
                end
                OFF_IRQ_EN:
                begin
                    prdata[ST_ACT_FLAG] = ie_reg.active_match_flag;
                    prdata[ST_LEN_FLAG] = ie_reg.length_match_flag;
                end
                OFF_CARRIER:
                begin
                    prdata[CAR_PER_LSB +: 8]  = per_reg;
                    prdata[CAR_DUTY_LSB +: 8] = duty_reg;
                end
                default: prdata = '0;
            endcase
        end
    end

    // ========================================
    // Checks
    AST_ONESHOT_STOP: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        os_stop && !ctl_rst |=> !run_reg)
        else $error("one-shot did not stop run");
    AST_CNT_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        bit_match && !cnt_rst_reg |=> data_cnt_reg == DATA_ZERO)
        else $error("data counter did not wrap");
    AST_CAR_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        car_per |=> car_cnt_reg == CARR_ZERO && car_wave_reg != $past(car_wave_reg))
        else $error("carrier did not wrap");
    AST_DUTY_TOG: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        car_duty && !car_per |=> car_wave_reg != $past(car_wave_reg))
        else $error("carrier duty toggle missing");
    AST_ACT_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        act_match |=> flag_reg.active_match_flag)
        else $error("active flag not set");
    AST_LEN_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        bit_match |=> flag_reg.length_match_flag)
        else $error("length flag not set");
    AST_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        bit_match && ie_reg.length_match_flag && !wr_ie |=> irq)
        else $error("irq missing after length match");
    AST_PIN_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        !run_reg ##1 !run_reg |-> !remote_output_pin && !clear_pulse_pin)
        else $error("pins active while stopped");
    AST_BUSY_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        buf_en && act_busy_reg && wr_act |=> act_len_reg == $past(act_len_reg))
        else $error("busy write accepted");
    AST_SHADOW: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
        buf_en && bit_match && !bit_take
        |=> bit_buf_reg == $past(bit_len_reg) && !bit_busy_reg)
        else $error("shadow not loaded");

endmodule

// ===== tb/irp_emitter_model.sv
// Emitter and lamp side model: measures what the unit drives on its pins
`timescale 1ns/1ns
module irp_emitter_model
(
    input  wire logic        core_clk,   // Unit clock
    input  wire logic        clr,        // Clears counts and run state, not the last widths and period
    input  wire logic        remote_in,  // Modulated IR output seen
    input  wire logic        clear_in,   // Lamp clear pulse seen
    output logic      [31:0] rem_high,   // Cycles with remote high
    output logic      [31:0] clr_high,   // Cycles with clear pulse high
    output logic      [31:0] rem_width,  // Last remote high width
    output logic      [31:0] rem_period, // Last remote rise to rise
    output logic      [31:0] clr_width   // Last clear pulse width
);
    logic [31:0] run_w;
    logic [31:0] run_p;
    logic [31:0] run_c;
    logic        rem_q;
    logic        clr_q;

    // ==========================================================
    // Pulse measurement
    always_ff @(posedge core_clk)
    begin
        if (clr)
        begin
            rem_high <= 32'h0;
            clr_high <= 32'h0;
            run_w    <= 32'h0;
            run_p    <= 32'h0;
            run_c    <= 32'h0;
            rem_q    <= 1'b0;
            clr_q    <= 1'b0;
        end
        else
        begin
            rem_high <= rem_high + {31'h0, remote_in};
            clr_high <= clr_high + {31'h0, clear_in};
            run_w    <= remote_in ? run_w + 32'h1 : 32'h0;
            run_p    <= (remote_in && !rem_q) ? 32'h1 : run_p + 32'h1;
            run_c    <= clear_in ? run_c + 32'h1 : 32'h0;
            if (!remote_in && rem_q)
                rem_width <= run_w;
            if (remote_in && !rem_q)
                rem_period <= run_p;
            if (!clear_in && clr_q)
                clr_width <= run_c;
            rem_q    <= remote_in;
            clr_q    <= clear_in;
        end
    end
endmodule

// ===== tb/irp_pulse_unit_bench.sv
// Self-checking bench for the IR pulse unit, driven over APB
`timescale 1ns/1ns
module irp_pulse_unit_bench
    import irp_pkg::*;
;
    localparam logic [31:0] EN   = 32'h1 << CTL_MODULE_EN;
    localparam logic [31:0] SRST = 32'h1 << CTL_SOFT_RST;
    localparam logic [31:0] ONE  = 32'h1 << CTL_ONESHOT;
    localparam logic [31:0] BUF  = 32'h1 << CTL_BUF_EN;
    localparam logic [31:0] INV  = 32'h1 << CTL_INVERT;
    localparam logic [31:0] GO   = (32'h1 << CTL_RUN) | (32'h1 << CTL_CNT_RST);

    logic        core_clk = 1'b0;
    logic        resetn, psel, penable, pwrite, pready, pslverr, clr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, q2;
    logic        remote_output_pin, clear_pulse_pin, irq, perr;
    logic [31:0] rem_high, clr_high, rem_width, rem_period, clr_width;
    int          errors = 0;
    int          comparisons = 0;

    irp_pulse_unit dut (.core_clk(core_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .remote_output_pin(remote_output_pin),
        .clear_pulse_pin(clear_pulse_pin), .irq(irq));

    irp_emitter_model em (.core_clk(core_clk), .clr(clr),
        .remote_in(remote_output_pin), .clear_in(clear_pulse_pin),
        .rem_high(rem_high), .clr_high(clr_high), .rem_width(rem_width),
        .rem_period(rem_period), .clr_width(clr_width));

    always #5 core_clk = ~core_clk;

    // ==========================================================
    // APB master and comparison helpers
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask

    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rdm(input string nm, input logic [11:0] a,
                       input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        cmp(nm, e, r & m);
    endtask

    // Bounded wait until masked register field equals want
    task automatic poll(input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] want);
        int i;
        logic [31:0] r;
        for (i = 0; i < 3000; i++)
        begin
            xfer(1'b0, a, 32'h0, r);
            if ((r & m) === want)
                break;
        end
        cmp("poll", want, r & m);
    endtask

    task automatic pulse_clr();
        @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
    endtask

    task automatic summarize();
        if (errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        errors++;
        summarize();
    end

    // ==========================================================
    // Test sequence
    initial
    begin
        logic [11:0] offs [6];
        offs = '{OFF_CTRL, OFF_CNT, OFF_ACT_LEN, OFF_BIT_LEN, OFF_STATUS,
                 OFF_IRQ_EN};
        resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; clr = 1'b1;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        clr    <= 1'b0;
        repeat (3) @(posedge core_clk);
        foreach (offs[i])
            rdm("reset value", offs[i], 32'hFFFFFFFF, 32'h0);
        xfer(1'b0, 12'h01C, 32'h0, q);
        cmp("unmapped data", 32'h0, q);
        cmp("unmapped error", 32'h1, {31'h0, perr});
        wr(OFF_ACT_LEN, 32'h5);
        rdm("length while disabled", OFF_ACT_LEN, 32'hFFFF, 32'h0);

        // One-shot bit, carrier held high across the data pulse
        wr(OFF_CTRL, EN | ONE);
        wr(OFF_CARRIER, 32'h0000FFFE);
        wr(OFF_ACT_LEN, 32'h5);
        wr(OFF_BIT_LEN, 32'h13);
        pulse_clr();
        wr(OFF_CTRL, EN | ONE | GO);
        poll(OFF_STATUS, 32'h2, 32'h2);
        repeat (4) @(posedge core_clk);
        rdm("run after one-shot", OFF_CTRL, 32'h100, 32'h0);
        rdm("status", OFF_STATUS, 32'h403, 32'h3);
        cmp("remote high", 32'h6, rem_high);
        cmp("clear high", 32'hE, clr_high);
        cmp("remote idle", 32'h0, {31'h0, remote_output_pin});
        cmp("clear idle", 32'h0, {31'h0, clear_pulse_pin});

        // Interrupt enables against flags
        wr(OFF_IRQ_EN, 32'h2);
        #1 cmp("irq length", 32'h1, {31'h0, irq});
        wr(OFF_STATUS, 32'h2);
        #1 cmp("irq cleared", 32'h0, {31'h0, irq});
        rdm("flags", OFF_STATUS, 32'h3, 32'h1);
        wr(OFF_IRQ_EN, 32'h1);
        #1 cmp("irq active", 32'h1, {31'h0, irq});
        wr(OFF_STATUS, 32'h1);
        #1 cmp("irq none", 32'h0, {31'h0, irq});

        // Inverted output, then soft reset
        wr(OFF_CTRL, EN | ONE | INV);
        pulse_clr();
        wr(OFF_CTRL, EN | ONE | INV | GO);
        poll(OFF_STATUS, 32'h2, 32'h2);
        repeat (4) @(posedge core_clk);
        cmp("inverted high", 32'hE, rem_high);
        wr(OFF_CTRL, EN | SRST);
        rdm("flags after reset", OFF_STATUS, 32'h403, 32'h0);
        rdm("reset bit", OFF_CTRL, SRST, 32'h0);
        rdm("counter", OFF_CNT, 32'hFFFF, 32'h0);

        // Repeat mode with a fast carrier
        wr(OFF_CTRL, EN);
        wr(OFF_CARRIER, 32'h00000301);
        wr(OFF_ACT_LEN, 32'hC7);
        wr(OFF_BIT_LEN, 32'h18F);
        wr(OFF_CTRL, EN | GO);
        poll(OFF_STATUS, 32'h2, 32'h2);
        wr(OFF_STATUS, 32'h3);
        poll(OFF_CNT, 32'h40, 32'h40);
        cmp("carrier high", 32'h2, rem_width);
        cmp("carrier period", 32'h4, rem_period);
        poll(OFF_STATUS, 32'h2, 32'h2);
        rdm("still running", OFF_STATUS, 32'h400, 32'h400);
        wr(OFF_CTRL, EN);
        repeat (3) @(posedge core_clk);
        xfer(1'b0, OFF_CNT, 32'h0, q);
        xfer(1'b0, OFF_CNT, 32'h0, q2);
        cmp("stopped counter", q, q2);
        cmp("remote stopped", 32'h0, {31'h0, remote_output_pin});
        wr(OFF_CTRL, 32'h0);

        // Buffered lengths for gapless bits
        wr(OFF_CTRL, EN);
        wr(OFF_ACT_LEN, 32'h63);
        wr(OFF_BIT_LEN, 32'hC7);
        wr(OFF_CTRL, EN | BUF);
        wr(OFF_CTRL, EN | BUF | GO);
        wr(OFF_ACT_LEN, 32'h4);
        rdm("active busy", OFF_STATUS, 32'h100, 32'h100);
        wr(OFF_ACT_LEN, 32'h7);
        rdm("busy write", OFF_ACT_LEN, 32'hFFFF, 32'h4);
        wr(OFF_BIT_LEN, 32'h1D);
        poll(OFF_STATUS, 32'h300, 32'h0);
        repeat (2) @(posedge core_clk);
        cmp("first clear width", 32'h64, clr_width);
        wr(OFF_STATUS, 32'h3);
        poll(OFF_STATUS, 32'h2, 32'h2);
        repeat (2) @(posedge core_clk);
        cmp("next clear width", 32'h19, clr_width);
        wr(OFF_CTRL, EN);
        wr(OFF_CTRL, 32'h0);
        summarize();
    end
endmodule
